// ### verilog/cspcc_pkg.sv
package cspcc_pkg;

  // Bus geometry
  localparam int unsigned AHB_AW       = 32;  // Address width
  localparam int unsigned AHB_DW       = 32;  // Data width
  localparam int unsigned OFS_W        = 8;   // Decoded offset width
  localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
  localparam logic        HRESP_OKAY   = 1'h0;

  // Register byte offsets
  localparam logic [7:0]  OFS_STATE    = 8'h08;  // Present state
  localparam logic [7:0]  OFS_FORCE    = 8'h0c;  // Force / retest
  localparam logic [7:0]  OFS_CTRL     = 8'h10;  // Voltage and clock-run
  localparam logic [7:0]  OFS_PM       = 8'h20;  // Clock power management
  localparam logic [7:0]  OFS_ISTAT    = 8'h30;  // Interrupt status
  localparam logic [7:0]  OFS_IMASK    = 8'h34;  // Interrupt mask
  localparam logic [7:0]  OFS_CFG      = 8'h38;  // Diagnostic config

  // Socket control fields
  localparam int unsigned CTRL_ACT_BIT   = 11;
  localparam int unsigned CTRL_STDZV_BIT = 10;
  localparam int unsigned CTRL_VIDEO_PORT_ENABLE_BIT  = 9;
  localparam int unsigned CTRL_STOP_BIT  = 7;
  localparam int unsigned CTRL_VCC_LSB   = 4;
  localparam int unsigned CTRL_VPP_LSB   = 0;
  localparam int unsigned VFIELD_W       = 3;
  localparam logic [31:0] CTRL_RSVD_MASK = 32'hfffff108;

  // Power management fields
  localparam int unsigned PM_ACC_BIT     = 25;
  localparam int unsigned PM_MODE_BIT    = 24;
  localparam int unsigned PM_EN_BIT      = 16;
  localparam int unsigned PM_SEL_BIT     = 0;
  localparam logic [31:0] PM_RSVD_MASK   = 32'hfcfefffe;

  // Present state and force fields
  localparam int unsigned ST_PWR_BIT     = 3;
  localparam int unsigned ST_BAD_BIT     = 9;
  localparam int unsigned CAP_LSB        = 10;  // 5V, 3V, XV, YV upward
  localparam int unsigned CAP_W          = 4;
  localparam int unsigned FORCE_RETEST_BIT = 14;
  localparam int unsigned CFG_STDZV_BIT  = 0;

  // Voltage codes
  localparam logic [2:0]  V_OFF  = 3'h0;
  localparam logic [2:0]  V_12V  = 3'h1;  // Program voltage only
  localparam logic [2:0]  V_5V   = 3'h2;
  localparam logic [2:0]  V_3V3  = 3'h3;
  localparam logic [2:0]  V_XV   = 3'h4;
  localparam logic [2:0]  V_YV   = 3'h5;

  // Capability flag positions inside the cap field
  localparam int unsigned CAPI_5V = 0;
  localparam int unsigned CAPI_3V = 1;
  localparam int unsigned CAPI_XV = 2;
  localparam int unsigned CAPI_YV = 3;

  // Interrupt events
  localparam int unsigned IRQ_W      = 4;
  localparam int unsigned IRQ_ACCESS = 0;
  localparam int unsigned IRQ_BADREQ = 1;
  localparam int unsigned IRQ_PWRUPD = 2;
  localparam int unsigned IRQ_RATE   = 3;

  // Reset values
  localparam logic        CTRL_ON_RST = 1'h1;  // Control register usable
  localparam logic        FLAG_RST    = 1'h0;

  // Card clock timing
  localparam int unsigned CORE_CLK_NS      = 50;
  localparam int unsigned CARD_CLK_NORM_NS = 400;
  localparam int unsigned CARD_CLK_CYC     = CARD_CLK_NORM_NS / CORE_CLK_NS;
  localparam int unsigned RATE_GAP_CYC     = 2 * CARD_CLK_CYC;
  localparam int unsigned GAP_CNT_W        = 8;

  // Bus phase states
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WAIT = 2'b01,
    PH_DONE = 2'b10
  } cspcc_phase_type;

endpackage

// ### verilog/cspcc_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser bank for pins from outside the core clock
module cspcc_sync
#(
  parameter int unsigned WIDTH = 1
)
(
  input  wire  logic             core_clk,
  input  wire  logic             rst_n,
  input  wire  logic [WIDTH-1:0] async_in,
  output logic       [WIDTH-1:0] sync_out
);

  // Refuse an empty bank
  if (WIDTH < 1)
  begin : g_chk
    $error("cspcc_sync: WIDTH must be at least one");
  end

  // One flop pair per bit; the first flop feeds only the second
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    logic meta_q;  // First stage
    logic sync_q;  // Second stage
    always_ff @(posedge core_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
      end
      else
      begin
        meta_q <= async_in[i];
        sync_q <= meta_q;
      end
    end
    assign sync_out[i] = sync_q;
  end

endmodule // cspcc_sync

// ### verilog/cspcc_top.sv
`timescale 1ns/1ps
module cspcc_top
#(
  parameter int unsigned GAP_LIMIT_CYC = cspcc_pkg::RATE_GAP_CYC
)
(
  input  wire  logic                           core_clk,
  input  wire  logic                           rst_n,
  input  wire  logic                           hsel,
  input  wire  logic [cspcc_pkg::AHB_AW-1:0]   haddr,
  input  wire  logic [1:0]                     htrans,
  input  wire  logic                           hwrite,
  input  wire  logic [2:0]                     hsize,
  input  wire  logic [cspcc_pkg::AHB_DW-1:0]   hwdata,
  input  wire  logic                           hready,
  output logic       [cspcc_pkg::AHB_DW-1:0]   hrdata,
  output logic                                 hreadyout,
  output logic                                 hresp,
  input  wire  logic                           card_access,
  input  wire  logic                           socket_idle,
  input  wire  logic                           host_clock_stop_pending,
  input  wire  logic                           card_clk,
  input  wire  logic [cspcc_pkg::CAP_W-1:0]    card_volt_caps,
  output logic                                 pwr_update_strobe,
  output logic       [cspcc_pkg::VFIELD_W-1:0] pwr_vcc_code,
  output logic       [cspcc_pkg::VFIELD_W-1:0] pwr_vpp_code,
  output logic                                 video_port_enable,
  output logic                                 card_clock_stop_req,
  output logic                                 card_clock_slow_req,
  output logic                                 irq
);
  import cspcc_pkg::*;

  // Gap limit must fit the counter and be at least two cycles
  if (GAP_LIMIT_CYC < 2 || GAP_LIMIT_CYC >= (1 << GAP_CNT_W))
  begin : g_chk
    $error("cspcc_top: GAP_LIMIT_CYC out of range");
  end

  localparam logic [GAP_CNT_W-1:0] GAP_LIM = GAP_CNT_W'(GAP_LIMIT_CYC);

  // Supply code is a defined, non-reserved level
  function automatic logic vcc_on(input logic [2:0] c);
    vcc_on = (c == V_5V) || (c == V_3V3) || (c == V_XV) || (c == V_YV);
  endfunction

  // Supply code is off or suits the card capabilities
  function automatic logic vcc_fits(input logic [2:0] c,
                                    input logic [CAP_W-1:0] k);
    vcc_fits = (c == V_OFF) || (c == V_5V && k[CAPI_5V])
             || (c == V_3V3 && k[CAPI_3V]) || (c == V_XV && k[CAPI_XV])
             || (c == V_YV && k[CAPI_YV]);
  endfunction

  // Pin synchronisation
  logic [CAP_W+2:0] pin_s;  // Synchronised pins
  cspcc_sync #(.WIDTH(CAP_W + 3)) u_sync
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in ({card_clk, socket_idle, card_access, card_volt_caps}),
    .sync_out (pin_s)
  );
  wire logic [CAP_W-1:0] caps_s   = pin_s[CAP_W-1:0];
  wire logic             access_s = pin_s[CAP_W];
  wire logic             idle_s   = pin_s[CAP_W+1];
  wire logic             cclk_s   = pin_s[CAP_W+2];

  // Bus state
  cspcc_phase_type   phase_q;    // Transfer phase
  logic [OFS_W-1:0]  addr_q;     // Latched offset
  logic              addr_ok_q;  // Upper address bits zero
  logic              write_q;    // Latched direction
  logic [AHB_DW-1:0] hrdata_q;   // Read data register

  // Register state
  logic             video_port_enable_q, stop_pol_q, pm_en_q, pm_sel_q, std_en_q;
  logic [2:0]       vcc_q, vpp_q;          // Stored requests
  logic             ctrl_on_q;             // Control register usable
  logic [CAP_W-1:0] caps_q;                // Card capabilities
  logic             bad_q, powered_q;      // Present state flags
  logic             acc_q, rate_q;         // Access and rate status
  logic [IRQ_W-1:0] istat_q, imask_q;      // Interrupt status and mask
  logic             strobe_q;              // Switch update pulse
  logic [2:0]       pvcc_q, pvpp_q;        // Switch codes
  logic             stop_q, slow_q;        // Clock-run requests
  logic             cclk_prev_q;           // Card clock edge detect
  logic [GAP_CNT_W-1:0] gap_q;             // Cycles since card edge

  // Address phase acceptance and decode
  wire logic take    = hsel && htrans == HTRANS_NSEQ && hready;
  wire logic in_wait = (phase_q == PH_WAIT);
  wire logic wr      = in_wait && write_q;
  wire logic rd      = in_wait && !write_q;
  wire logic s_ctrl  = addr_ok_q && addr_q == OFS_CTRL;
  wire logic s_pm    = addr_ok_q && addr_q == OFS_PM;
  wire logic s_state = addr_ok_q && addr_q == OFS_STATE;
  wire logic s_force = addr_ok_q && addr_q == OFS_FORCE;
  wire logic s_istat = addr_ok_q && addr_q == OFS_ISTAT;
  wire logic s_imask = addr_ok_q && addr_q == OFS_IMASK;
  wire logic s_cfg   = addr_ok_q && addr_q == OFS_CFG;
  wire cspcc_phase_type phase_d = take ? PH_WAIT
                                : (in_wait ? PH_DONE : PH_IDLE);

  // Write side: request fields and power switch decision
  wire logic [2:0] new_vcc  = hwdata[CTRL_VCC_LSB +: VFIELD_W];
  wire logic [2:0] new_vpp  = hwdata[CTRL_VPP_LSB +: VFIELD_W];
  wire logic       new_video_port_enable = hwdata[CTRL_VIDEO_PORT_ENABLE_BIT];
  wire logic       ctrl_wr  = wr && s_ctrl;
  wire logic       issue    = ctrl_wr && ctrl_on_q
                            && (new_vcc != vcc_q || new_vpp != vpp_q);
  wire logic       refused  = issue && vcc_on(new_vcc)
                            && !vcc_fits(new_vcc, caps_q);
  wire logic [2:0] vcc_gnt  = (vcc_on(new_vcc) && !refused)
                            ? new_vcc : V_OFF;
  wire logic       vpp_ok   = (new_vpp != V_OFF) && (new_vpp <= V_YV);
  wire logic [2:0] vpp_gnt  = (vpp_ok && vcc_gnt != V_OFF)
                            ? new_vpp : V_OFF;

  // Force register actions
  wire logic force_wr  = wr && s_force;
  wire logic retest    = force_wr && hwdata[FORCE_RETEST_BIT];
  wire logic cap_force = force_wr && |hwdata[CAP_LSB +: CAP_W];

  // Clock-run permission
  wire logic permit = idle_s && (stop_pol_q || host_clock_stop_pending);
  wire logic active = pm_en_q && permit;

  // Card clock rate watch
  wire logic cclk_rise = cclk_s && !cclk_prev_q;
  wire logic gap_hit   = (gap_q >= GAP_LIM);
  wire logic held      = stop_q || slow_q;
  wire logic rate_d    = (cclk_rise && !gap_hit) ? 1'b0
                       : ((held && gap_hit) ? 1'b1 : rate_q);

  // Interrupt events and clear
  wire logic [IRQ_W-1:0] ev =
      (IRQ_W'(access_s && !acc_q) << IRQ_ACCESS)
    | (IRQ_W'(refused)           << IRQ_BADREQ)
    | (IRQ_W'(issue)             << IRQ_PWRUPD)
    | (IRQ_W'(rate_d && !rate_q) << IRQ_RATE);
  wire logic [IRQ_W-1:0] iclr = (wr && s_istat) ? hwdata[IRQ_W-1:0] : '0;

  // Read words
  wire logic [31:0] ctrl_word = (32'(video_port_enable_q)      << CTRL_ACT_BIT)
                              | (32'(!std_en_q)   << CTRL_STDZV_BIT)
                              | (32'(video_port_enable_q)      << CTRL_VIDEO_PORT_ENABLE_BIT)
                              | (32'(stop_pol_q)  << CTRL_STOP_BIT)
                              | (32'(vcc_q)       << CTRL_VCC_LSB)
                              | (32'(vpp_q)       << CTRL_VPP_LSB);
  wire logic [31:0] pm_word   = (32'(acc_q)       << PM_ACC_BIT)
                              | (32'(rate_q)      << PM_MODE_BIT)
                              | (32'(pm_en_q)     << PM_EN_BIT)
                              | (32'(pm_sel_q)    << PM_SEL_BIT);
  wire logic [31:0] st_word   = (32'(powered_q)   << ST_PWR_BIT)
                              | (32'(bad_q)       << ST_BAD_BIT)
                              | (32'(caps_q)      << CAP_LSB);
  wire logic [31:0] rd_word   = s_ctrl  ? ctrl_word
                              : s_pm    ? pm_word
                              : s_state ? st_word
                              : s_istat ? 32'(istat_q)
                              : s_imask ? 32'(imask_q)
                              : s_cfg   ? 32'(std_en_q) : '0;

  // Bus phase and latched address
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_q   <= PH_IDLE;
      addr_q    <= '0;
      addr_ok_q <= 1'b0;
      write_q   <= 1'b0;
    end
    else
    begin
      phase_q <= phase_d;
      if (take)
      begin
        addr_q    <= {haddr[OFS_W-1:2], 2'b00};
        addr_ok_q <= (haddr[AHB_AW-1:OFS_W] == '0);
        write_q   <= hwrite;
      end
    end
  end

  // Read data register, loaded in the wait cycle
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      hrdata_q <= '0;
    else if (rd)
      hrdata_q <= rd_word;
  end

  // Socket control register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      video_port_enable_q     <= FLAG_RST;
      stop_pol_q <= FLAG_RST;
      vcc_q      <= V_OFF;
      vpp_q      <= V_OFF;
    end
    else if (ctrl_wr)
    begin
      video_port_enable_q     <= new_video_port_enable;
      stop_pol_q <= hwdata[CTRL_STOP_BIT];
      vcc_q      <= new_vcc;
      vpp_q      <= new_vpp;
    end
  end

  // Power management and config registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pm_en_q  <= FLAG_RST;
      pm_sel_q <= FLAG_RST;
      std_en_q <= FLAG_RST;
      imask_q  <= '0;
    end
    else
    begin
      if (wr && s_pm)
      begin
        pm_en_q  <= hwdata[PM_EN_BIT];
        pm_sel_q <= hwdata[PM_SEL_BIT];
      end
      if (wr && s_cfg)
        std_en_q <= hwdata[CFG_STDZV_BIT];
      if (wr && s_imask)
        imask_q <= hwdata[IRQ_W-1:0];
    end
  end

  // Card interrogation state; retest wins over a forced flag
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_on_q <= CTRL_ON_RST;
      caps_q    <= '0;
      bad_q     <= FLAG_RST;
    end
    else if (retest)
    begin
      ctrl_on_q <= 1'b1;
      caps_q    <= caps_s;
      bad_q     <= 1'b0;
    end
    else
    begin
      if (cap_force)
      begin
        ctrl_on_q <= 1'b0;
        caps_q    <= caps_q | hwdata[CAP_LSB +: CAP_W];
      end
      if (refused)
        bad_q <= 1'b1;
    end
  end

  // Power switch update and powered status
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strobe_q  <= 1'b0;
      pvcc_q    <= V_OFF;
      pvpp_q    <= V_OFF;
      powered_q <= FLAG_RST;
    end
    else
    begin
      strobe_q <= issue;
      if (issue)
      begin
        pvcc_q    <= vcc_gnt;
        pvpp_q    <= vpp_gnt;
        powered_q <= (vcc_gnt != V_OFF);
      end
    end
  end

  // Access flag: an access in the clearing read cycle wins
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      acc_q <= FLAG_RST;
    else if (access_s)
      acc_q <= 1'b1;
    else if (rd && s_pm)
      acc_q <= 1'b0;
  end

  // Clock-run requests and card clock gap counter
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stop_q      <= 1'b0;
      slow_q      <= 1'b0;
      cclk_prev_q <= 1'b0;
      gap_q       <= '0;
      rate_q      <= FLAG_RST;
    end
    else
    begin
      stop_q      <= active && !pm_sel_q;
      slow_q      <= active && pm_sel_q;
      cclk_prev_q <= cclk_s;
      rate_q      <= rate_d;
      if (cclk_rise)
        gap_q <= '0;
      else if (!gap_hit)
        gap_q <= gap_q + 1'b1;
    end
  end

  // Sticky interrupt status; set wins over write-one clear
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      istat_q <= '0;
    else
      istat_q <= (istat_q & ~iclr) | ev;
  end

  // Outputs
  assign hrdata              = hrdata_q;
  assign hreadyout           = !in_wait;
  assign hresp               = HRESP_OKAY;
  assign pwr_update_strobe   = strobe_q;
  assign pwr_vcc_code        = pvcc_q;
  assign pwr_vpp_code        = pvpp_q;
  assign video_port_enable   = video_port_enable_q;
  assign card_clock_stop_req = stop_q;
  assign card_clock_slow_req = slow_q;
  assign irq                 = |(istat_q & imask_q);

  // Completed reads, as seen in the data phase end cycle
  wire logic done_rd = (phase_q == PH_DONE) && !write_q;

  property p_ctrl_rsvd;
    @(posedge core_clk) disable iff (!rst_n)
    done_rd && s_ctrl |-> (hrdata_q & CTRL_RSVD_MASK) == '0;
  endproperty
  a_ctrl_rsvd: assert property (p_ctrl_rsvd)
    else $error("control reserved bits not zero");

  property p_act_mirror;
    @(posedge core_clk) disable iff (!rst_n)
    done_rd && s_ctrl |-> hrdata_q[CTRL_ACT_BIT] == hrdata_q[CTRL_VIDEO_PORT_ENABLE_BIT];
  endproperty
  a_act_mirror: assert property (p_act_mirror)
    else $error("video activity does not follow enable");

  property p_std_model;
    @(posedge core_clk) disable iff (!rst_n)
    done_rd && s_ctrl |-> hrdata_q[CTRL_STDZV_BIT] == !std_en_q;
  endproperty
  a_std_model: assert property (p_std_model)
    else $error("standard model bit wrong");

  property p_video_port_enable_write;
    @(posedge core_clk) disable iff (!rst_n)
    ctrl_wr |=> video_port_enable == $past(new_video_port_enable);
  endproperty
  a_video_port_enable_write: assert property (p_video_port_enable_write)
    else $error("video enable not written");

  property p_policy;
    @(posedge core_clk) disable iff (!rst_n)
    (card_clock_stop_req || card_clock_slow_req) |-> $past(idle_s)
      && ($past(stop_pol_q) || $past(host_clock_stop_pending));
  endproperty
  a_policy: assert property (p_policy)
    else $error("clock-run request outside policy");

  property p_pm_rsvd;
    @(posedge core_clk) disable iff (!rst_n)
    done_rd && s_pm |-> (hrdata_q & PM_RSVD_MASK) == '0;
  endproperty
  a_pm_rsvd: assert property (p_pm_rsvd)
    else $error("management reserved bits not zero");

  property p_acc_clear;
    @(posedge core_clk) disable iff (!rst_n)
    rd && s_pm && !access_s |=> !acc_q;
  endproperty
  a_acc_clear: assert property (p_acc_clear)
    else $error("access flag not cleared by read");

  property p_enable_gate;
    @(posedge core_clk) disable iff (!rst_n)
    (card_clock_stop_req || card_clock_slow_req) |-> $past(pm_en_q)
      && card_clock_slow_req == $past(pm_sel_q);
  endproperty
  a_enable_gate: assert property (p_enable_gate)
    else $error("clock control acted while disabled or wrong mode");

  property p_retest;
    @(posedge core_clk) disable iff (!rst_n)
    retest |=> ctrl_on_q;
  endproperty
  a_retest: assert property (p_retest)
    else $error("retest did not re-enable control");

  property p_force_off;
    @(posedge core_clk) disable iff (!rst_n)
    cap_force && !retest |=> !ctrl_on_q ##1 !strobe_q;
  endproperty
  a_force_off: assert property (p_force_off)
    else $error("forced flag did not disable control");

  property p_strobe;
    @(posedge core_clk) disable iff (!rst_n)
    pwr_update_strobe |-> $past(ctrl_on_q) && vcc_fits(pwr_vcc_code, caps_q)
      && powered_q == (pwr_vcc_code != V_OFF) ##1 !pwr_update_strobe;
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("bad power switch update");

  property p_legal_code;
    @(posedge core_clk) disable iff (!rst_n)
    pwr_update_strobe && pwr_vcc_code != V_OFF |-> vcc_on(pwr_vcc_code);
  endproperty
  a_legal_code: assert property (p_legal_code)
    else $error("reserved code sent to power switch");

  property p_rate;
    @(posedge core_clk) disable iff (!rst_n)
    $rose(rate_q) |-> $past(held) && $past(gap_hit);
  endproperty
  a_rate: assert property (p_rate)
    else $error("rate status rose without clock-run");

  c_pwr_on:  cover property (@(posedge core_clk) disable iff (!rst_n)
    pwr_update_strobe && pwr_vcc_code != V_OFF);
  c_refused: cover property (@(posedge core_clk) disable iff (!rst_n)
    refused);
  c_slowed:  cover property (@(posedge core_clk) disable iff (!rst_n)
    card_clock_slow_req && rate_q);
  c_irq:     cover property (@(posedge core_clk) disable iff (!rst_n)
    $rose(irq));

endmodule // cspcc_top

// ### sim/cspcc_socket_model.sv
`timescale 1ns/1ps
// Card socket with its power switch
module cspcc_socket_model
#(
  parameter logic [3:0] CAPS = 4'h3  // Card suits 5V and 3.3V
)
(
  input  wire  logic       core_clk,
  input  wire  logic       rst_n,
  input  wire  logic       stop_req,
  input  wire  logic       slow_req,
  input  wire  logic       strobe,
  input  wire  logic [2:0] vcc,
  input  wire  logic [2:0] vpp,
  output logic             card_clk,
  output logic       [3:0] caps,
  output logic       [2:0] app_vcc,
  output logic       [2:0] app_vpp,
  output int               n_upd
);
  // Capability pins are static for this card
  assign caps = CAPS;
  // 400 ns clock, slowed by 16 or held still on request
  initial
  begin
    card_clk = 1'b0;
    #37;
    forever
    begin
      #(slow_req ? 3200 : 200);
      if (!stop_req)
        card_clk = ~card_clk;
    end
  end
  // Switch applies both codes on each update pulse
  always @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      app_vcc <= 3'h0;
      app_vpp <= 3'h0;
      n_upd   <= 0;
    end
    else if (strobe === 1'b1)
    begin
      app_vcc <= vcc;
      app_vpp <= vpp;
      n_upd   <= n_upd + 1;
    end
endmodule // cspcc_socket_model

// ### sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import cspcc_pkg::*;
  logic        core_clk = 0, rst_n = 0, hsel = 0, hwrite = 0;
  logic        card_access = 0, socket_idle = 0, host_pend = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
  logic [1:0]  htrans = '0;
  logic        hreadyout, hresp, card_clk, strobe, stop, slow, vpe, irq;
  logic [3:0]  caps;
  logic [2:0]  vcc, vpp, avcc, avpp;
  int          num_errors = 0, num_checks = 0, nupd, prev;

  cspcc_top u_dut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .card_access(card_access),
    .socket_idle(socket_idle), .host_clock_stop_pending(host_pend),
    .card_clk(card_clk), .card_volt_caps(caps),
    .pwr_update_strobe(strobe), .pwr_vcc_code(vcc), .pwr_vpp_code(vpp),
    .video_port_enable(vpe), .card_clock_stop_req(stop),
    .card_clock_slow_req(slow), .irq(irq));
  cspcc_socket_model u_sock (.core_clk(core_clk), .rst_n(rst_n),
    .stop_req(stop), .slow_req(slow), .strobe(strobe), .vcc(vcc),
    .vpp(vpp), .card_clk(card_clk), .caps(caps), .app_vcc(avcc),
    .app_vpp(avpp), .n_upd(nupd));

  // Core clock, 50 ns
  initial
    forever #25 core_clk = ~core_clk;

  // Compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Wait for ready, sampled at the rising edge; no timeout of its own, the watchdog ends a hang
  task wait_rdy;
    @(posedge core_clk);
    while (hreadyout !== 1'b1)
      @(posedge core_clk);
  endtask

  // One single-word transfer; read data lands in r
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= HTRANS_NSEQ;
    wait_rdy;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    r = hrdata;
  endtask

  // Read, mask and compare
  task rc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(0, a, 0);
    chk(r & m, e);
  endtask

  // Report and stop
  task give_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    #1000000;
    num_errors++;
    give_verdict;
  end

  // Test sequence
  initial
  begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    rc(OFS_CTRL, '1, 32'h400);
    rc(OFS_PM, '1, 0);
    xfer(1, OFS_CTRL, '1);
    rc(OFS_CTRL, '1, 32'hef7);
    chk(vpe, 1);
    xfer(1, OFS_CFG, 1);
    rc(OFS_CTRL, '1, 32'haf7);
    xfer(1, OFS_CFG, 0);
    xfer(1, OFS_CTRL, 0);
    rc(OFS_CTRL, '1, 32'h400);
    xfer(1, OFS_FORCE, 32'h4000);
    rc(OFS_STATE, 32'h3c00, 32'hc00);
    // Every nonzero supply code with a 12V program request
    for (int c = 1; c < 8; c++)
    begin
      prev = nupd;
      xfer(1, OFS_CTRL, (c << 4) | 1);
      @(negedge core_clk);
      chk(nupd - prev, 1);
      chk(avcc, (c == 2 || c == 3) ? c : 0);
      chk(avpp, (c == 2 || c == 3) ? 1 : 0);
    end
    // Every program code at 5V supply
    for (int v = 0; v < 8; v++)
    begin
      xfer(1, OFS_CTRL, 32'h20 | v);
      @(negedge core_clk);
      chk(avpp, (v < 6) ? v : 0);
    end
    rc(OFS_STATE, 32'h208, 32'h208);
    xfer(1, OFS_FORCE, 32'h400);
    prev = nupd;
    xfer(1, OFS_CTRL, 32'h30);
    @(negedge core_clk);
    chk(nupd - prev, 0);
    xfer(1, OFS_FORCE, 32'h4000);
    xfer(1, OFS_CTRL, 0);
    @(negedge core_clk);
    chk(nupd - prev, 1);
    rc(OFS_STATE, 32'h8, 0);
    // Clock-run policy
    socket_idle <= 1'b1;
    xfer(1, OFS_PM, 32'h10000);
    repeat (6) @(posedge core_clk);
    chk({slow, stop}, 0);
    host_pend <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk({slow, stop}, 1);
    repeat (40) @(posedge core_clk);
    rc(OFS_PM, 32'h1000000, 32'h1000000);
    host_pend <= 1'b0;
    xfer(1, OFS_CTRL, 32'h80);
    repeat (6) @(posedge core_clk);
    chk(stop, 1);
    xfer(1, OFS_PM, '1);
    rc(OFS_PM, 32'hfcffffff, 32'h10001);
    chk({slow, stop}, 2);
    xfer(1, OFS_PM, 1);
    repeat (4) @(posedge core_clk);
    chk({slow, stop}, 0);
    // Access flag and interrupt
    xfer(1, OFS_ISTAT, 32'hf);
    xfer(0, OFS_PM, 0);
    card_access <= 1'b1;
    repeat (4) @(posedge core_clk);
    card_access <= 1'b0;
    chk(irq, 0);
    rc(OFS_PM, 32'h2000000, 32'h2000000);
    rc(OFS_PM, 32'h2000000, 0);
    xfer(1, OFS_IMASK, 1);
    @(negedge core_clk);
    chk(irq, 1);
    xfer(1, OFS_ISTAT, 1);
    @(negedge core_clk);
    chk(irq, 0);
    xfer(1, 32'h40, '1);
    rc(32'h40, '1, 0);
    chk(hresp, HRESP_OKAY);
    // Clock control off: card clock back at normal rate clears status
    repeat (80) @(posedge core_clk);
    rc(OFS_PM, 32'h1000000, 0);
    give_verdict;
  end
endmodule // tb_top
